// ==== design/pmic_params.svh ====
// constants of the power-management control block: offsets, fields, resets, timing
// assumes a 20 MHz system clock and a serial-bus pointer of eight bits
// What this block does
// - emergency off drops selected running converters
// - emergency off honoured only with rails regulating
// - enable starts regulator, then ordered default rails
// - enable low switches everything off, standby
// - adjustable rail set by six-bit code
// - step-up voltage set by six-bit code
// - step-up selectable backlight current or voltage
// - serial on/off for non-core blocks only
// - device is bus target, never drives clock
// - serial clock up to 400 kHz works
// - eight-pin port with pulse-width outputs
// - four pin modes: pulled input, two drains, hi-z
// - pin zero picks write address CEh or 8Eh
// - fault drives alert, host reads fault status
// - core feedback sampled at start marks core absent
// - fault pulls open-drain alert low
// - address latched at port supply rise only
`ifndef PMIC_PARAMS_SVH
`define PMIC_PARAMS_SVH

`define PMIC_REG_ENABLE 8'h00
`define PMIC_REG_OFFSEL 8'h01
`define PMIC_REG_RAIL_CODE 8'h02
`define PMIC_REG_STEPUP_CODE 8'h03
`define PMIC_REG_STEPUP_MODE 8'h04
`define PMIC_REG_LED_CURRENT 8'h05
`define PMIC_REG_PORT_CFG_LO 8'h06
`define PMIC_REG_PORT_CFG_HI 8'h07
`define PMIC_REG_PORT_OUT 8'h08
`define PMIC_REG_PORT_PWM 8'h09
`define PMIC_REG_PWM_DUTY 8'h0a
`define PMIC_REG_PORT_IN 8'h0b
`define PMIC_REG_FAULT 8'h0c
`define PMIC_REG_STATUS 8'h0d

`define PMIC_EN_FIVE 0
`define PMIC_EN_RAIL 1
`define PMIC_EN_STEPUP 2
`define PMIC_EN_LOADSW 3
`define PMIC_EN_SENSE 4
`define PMIC_EN_COMPAR 5
`define PMIC_OFF_MASK 6'h07

`define PMIC_RST_ENABLE 6'h00
`define PMIC_RST_OFFSEL 6'h00
`define PMIC_RST_CODE 6'h00
`define PMIC_RST_PORT_CFG 16'h0000
`define PMIC_RST_BYTE 8'h00

`define PMIC_WADDR_HI 8'hce
`define PMIC_WADDR_LO 8'h8e

`define PMIC_CLK_MHZ 20
`define PMIC_STEP_US 100
`define PMIC_STEP_CYC (`PMIC_STEP_US * `PMIC_CLK_MHZ)
`define PMIC_I2C_MAX_KHZ 400

`endif

// ==== design/pmic_pkg.sv ====
// types shared by the power-management control block
// assumes nothing of its surroundings
package pmic_pkg;
    typedef enum logic [2:0] {SQ_OFF, SQ_REG, SQ_CORE, SQ_MEM, SQ_IO, SQ_FIVE, SQ_ON} pmic_seq_t;
    typedef enum logic [2:0] {IC_IDLE, IC_ADDR, IC_PTR, IC_WDATA, IC_READ} pmic_i2c_t;
    typedef enum logic [1:0] {PM_IN_PULL, PM_OD_PULL, PM_OD_FLOAT, PM_HIZ} pmic_pin_mode_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } pmic_wr_t;
    typedef struct packed {
        logic internal_regulator;
        logic core_rail;
        logic memory_rail;
        logic io_rail;
        logic five_volt_rail;
        logic adjustable_rail;
        logic step_up_converter;
        logic load_switch;
        logic current_sense_amp;
        logic uncommitted_comparator;
    } pmic_rails_t;
    typedef struct packed {
        logic [5:0] rail_code;
        logic [5:0] stepup_code;
        logic stepup_volt_mode;
        logic [5:0] led_current;
    } pmic_analog_t;
endpackage : pmic_pkg

// ==== design/pmic_pin_sync.sv ====
// three-stage synchroniser with agreement filter for pins
// assumes inputs change slowly against clk_sys
`timescale 1ns/1ps
`default_nettype none
module pmic_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // raw pins and filtered copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            q <= INIT;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // a bit only moves once stages two and three agree
            q <= (s2_reg & s3_reg) | (q & (s2_reg ^ s3_reg));
        end
    end
endmodule : pmic_pin_sync
`default_nettype wire

// ==== design/pmic_ctrl.sv ====
// top of the power-management control logic: serial target, sequencer, port
// assumes open-drain bus wires resolved outside, pins asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "pmic_params.svh"
module pmic_ctrl #(
    parameter int STEP_CYC = `PMIC_STEP_CYC,
    parameter int NPIN = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_o,
    output logic sda_oe,
    // power control pins
    input wire logic emergency_off_n,
    input wire logic power_on_request,
    input wire logic core_rail_feedback,
    input wire logic [2:0] rail_good,
    input wire logic port_supply_good,
    input wire logic [7:0] fault_in,
    // rail controls
    output pmic_pkg::pmic_rails_t rail_en,
    output pmic_pkg::pmic_analog_t analog_cfg,
    // fault alert, open drain
    output logic fault_alert_n_o,
    output logic fault_alert_n_oe,
    // port pins
    input wire logic [NPIN-1:0] port_in,
    output logic [NPIN-1:0] port_o,
    output logic [NPIN-1:0] port_oe,
    output logic [NPIN-1:0] port_pullup
);
    localparam int SW = 1 + 1 + 1 + 1 + 1 + 3 + 1 + 8 + NPIN;
    localparam logic [SW-1:0] SYNC_INIT = {3'b111, {(SW-3){1'b0}}};

    logic [SW-1:0] fault_alert_n;
    logic scl_s, sda_s, off_s, pwr_s, fb_s, psup_s;
    logic [2:0] good_s;
    logic [7:0] fault_s;
    logic [NPIN-1:0] pin_s;

    // bus clock is sampled only, never driven; 400 kHz leaves >20 cycles a phase
    pmic_pin_sync #(.W(SW), .INIT(SYNC_INIT)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({scl_in, sda_in, emergency_off_n, power_on_request, core_rail_feedback,
            rail_good, port_supply_good, fault_in, port_in}),
        .q(fault_alert_n)
    );
    assign {scl_s, sda_s, off_s, pwr_s, fb_s, good_s, psup_s, fault_s, pin_s} = fault_alert_n;

    logic scl_d_reg, sda_d_reg, off_d_reg, psup_d_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            off_d_reg <= 1'b1;
            psup_d_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            off_d_reg <= off_s;
            psup_d_reg <= psup_s;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // address select, held until rst (main supply) comes again
    logic addr_latched_reg, addr_sel_reg;
    logic [7:0] my_waddr;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_latched_reg <= 1'b0;
            addr_sel_reg <= 1'b0;
        end else if (psup_s && !psup_d_reg && !addr_latched_reg) begin
            addr_latched_reg <= 1'b1;
            addr_sel_reg <= pin_s[0];
        end
    end
    assign my_waddr = addr_sel_reg ? `PMIC_WADDR_HI : `PMIC_WADDR_LO;

    // power sequencer
    pmic_pkg::pmic_seq_t seq_reg;
    logic [15:0] step_cnt_reg;
    logic core_absent_reg;
    logic step_done;
    assign step_done = step_cnt_reg == 16'(STEP_CYC - 1);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seq_reg <= pmic_pkg::SQ_OFF;
            step_cnt_reg <= 16'h0000;
            core_absent_reg <= 1'b0;
        end else if (!pwr_s) begin
            seq_reg <= pmic_pkg::SQ_OFF;
            step_cnt_reg <= 16'h0000;
        end else begin
            step_cnt_reg <= (step_done || seq_reg == pmic_pkg::SQ_ON) ? 16'h0000 : step_cnt_reg + 16'h0001;
            unique case (seq_reg)
                pmic_pkg::SQ_OFF: begin
                    seq_reg <= pmic_pkg::SQ_REG;
                    step_cnt_reg <= 16'h0000;
                end
                pmic_pkg::SQ_REG: if (step_done) begin
                    core_absent_reg <= fb_s;
                    seq_reg <= fb_s ? pmic_pkg::SQ_MEM : pmic_pkg::SQ_CORE;
                end
                pmic_pkg::SQ_CORE: if (step_done) seq_reg <= pmic_pkg::SQ_MEM;
                pmic_pkg::SQ_MEM: if (step_done) seq_reg <= pmic_pkg::SQ_IO;
                pmic_pkg::SQ_IO: if (step_done) seq_reg <= pmic_pkg::SQ_FIVE;
                pmic_pkg::SQ_FIVE: if (step_done) seq_reg <= pmic_pkg::SQ_ON;
                pmic_pkg::SQ_ON: seq_reg <= pmic_pkg::SQ_ON;
                default: seq_reg <= pmic_pkg::SQ_OFF;
            endcase
        end
    end

    logic good_all, emerg_evt, seq_on;
    assign seq_on = seq_reg == pmic_pkg::SQ_ON;
    assign good_all = (good_s[0] | core_absent_reg) & good_s[1] & good_s[2];
    assign emerg_evt = off_d_reg & ~off_s & good_all & seq_on;

    // serial target
    pmic_pkg::pmic_i2c_t ic_reg, nxt_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, ptr_reg, tx_reg, rd_data, rx_byte;
    logic ack_reg, wr_stb_reg;
    pmic_pkg::pmic_wr_t wr_reg;
    assign rx_byte = {shift_reg[6:0], sda_s};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ic_reg <= pmic_pkg::IC_IDLE;
            nxt_reg <= pmic_pkg::IC_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            tx_reg <= 8'h00;
            ack_reg <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb_reg <= 1'b0;
            wr_reg <= '0;
            sda_o <= 1'b0;
        end else begin
            wr_stb_reg <= 1'b0;
            sda_o <= 1'b0;
            if (bus_start) begin
                ic_reg <= pmic_pkg::IC_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                ic_reg <= pmic_pkg::IC_IDLE;
                sda_oe <= 1'b0;
            end else if (ic_reg != pmic_pkg::IC_IDLE && scl_rise) begin
                if (bit_cnt_reg != 4'h8) begin
                    shift_reg <= rx_byte;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'h7 && ic_reg != pmic_pkg::IC_READ) begin
                        ack_reg <= 1'b1;
                        unique case (ic_reg)
                            pmic_pkg::IC_ADDR:
                                if ({rx_byte[7:1], 1'b0} == my_waddr && addr_latched_reg)
                                    nxt_reg <= rx_byte[0] ? pmic_pkg::IC_READ : pmic_pkg::IC_PTR;
                                else begin
                                    // wrong address: stay silent until the next start
                                    ack_reg <= 1'b0;
                                    nxt_reg <= pmic_pkg::IC_IDLE;
                                end
                            pmic_pkg::IC_PTR: begin
                                ptr_reg <= rx_byte;
                                nxt_reg <= pmic_pkg::IC_WDATA;
                            end
                            pmic_pkg::IC_WDATA: begin
                                wr_stb_reg <= 1'b1;
                                wr_reg <= '{addr: ptr_reg, data: rx_byte};
                                nxt_reg <= pmic_pkg::IC_PTR;
                            end
                            default: nxt_reg <= pmic_pkg::IC_IDLE;
                        endcase
                    end
                end else begin
                    bit_cnt_reg <= 4'h0;
                    if (ic_reg == pmic_pkg::IC_READ) begin
                        if (sda_s) ic_reg <= pmic_pkg::IC_IDLE;
                        else ptr_reg <= ptr_reg + 8'h01;
                    end else begin
                        ic_reg <= nxt_reg;
                    end
                end
            end else if (ic_reg != pmic_pkg::IC_IDLE && scl_fall) begin
                // only ever pulls data low; the clock stays with the master
                if (bit_cnt_reg == 4'h8) sda_oe <= ack_reg && ic_reg != pmic_pkg::IC_READ;
                else if (ic_reg == pmic_pkg::IC_READ) begin
                    if (bit_cnt_reg == 4'h0) begin
                        tx_reg <= rd_data;
                        sda_oe <= ~rd_data[7];
                    end else begin
                        sda_oe <= ~tx_reg[3'd7 - bit_cnt_reg[2:0]];
                    end
                end else sda_oe <= 1'b0;
            end
        end
    end

    // control registers; defaults return whenever the chip is in standby
    logic [5:0] en_reg, offsel_reg, rail_code_reg, stepup_code_reg, led_reg;
    logic mode_reg;
    logic [2*NPIN-1:0] port_cfg_reg;
    logic [NPIN-1:0] pout_reg, pwm_en_reg;
    logic [7:0] duty_reg, fault_sts_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            en_reg <= `PMIC_RST_ENABLE;
            offsel_reg <= `PMIC_RST_OFFSEL;
            rail_code_reg <= `PMIC_RST_CODE;
            stepup_code_reg <= `PMIC_RST_CODE;
            led_reg <= `PMIC_RST_CODE;
            mode_reg <= 1'b0;
            port_cfg_reg <= `PMIC_RST_PORT_CFG;
            pout_reg <= `PMIC_RST_BYTE;
            pwm_en_reg <= `PMIC_RST_BYTE;
            duty_reg <= `PMIC_RST_BYTE;
        end else if (seq_reg == pmic_pkg::SQ_OFF) begin
            en_reg <= `PMIC_RST_ENABLE;
            offsel_reg <= `PMIC_RST_OFFSEL;
            rail_code_reg <= `PMIC_RST_CODE;
            stepup_code_reg <= `PMIC_RST_CODE;
            led_reg <= `PMIC_RST_CODE;
            mode_reg <= 1'b0;
            port_cfg_reg <= `PMIC_RST_PORT_CFG;
            pout_reg <= `PMIC_RST_BYTE;
            pwm_en_reg <= `PMIC_RST_BYTE;
            duty_reg <= `PMIC_RST_BYTE;
        end else begin
            if (wr_stb_reg) begin
                case (wr_reg.addr)
                    `PMIC_REG_ENABLE: en_reg <= wr_reg.data[5:0];
                    `PMIC_REG_OFFSEL: offsel_reg <= wr_reg.data[5:0];
                    `PMIC_REG_RAIL_CODE: rail_code_reg <= wr_reg.data[5:0];
                    `PMIC_REG_STEPUP_CODE: stepup_code_reg <= wr_reg.data[5:0];
                    `PMIC_REG_STEPUP_MODE: mode_reg <= wr_reg.data[0];
                    `PMIC_REG_LED_CURRENT: led_reg <= wr_reg.data[5:0];
                    `PMIC_REG_PORT_CFG_LO: port_cfg_reg[7:0] <= wr_reg.data;
                    `PMIC_REG_PORT_CFG_HI: port_cfg_reg[15:8] <= wr_reg.data;
                    `PMIC_REG_PORT_OUT: pout_reg <= wr_reg.data;
                    `PMIC_REG_PORT_PWM: pwm_en_reg <= wr_reg.data;
                    `PMIC_REG_PWM_DUTY: duty_reg <= wr_reg.data;
                    default: ;
                endcase
            end
            if (seq_reg == pmic_pkg::SQ_IO && step_done) en_reg[`PMIC_EN_FIVE] <= 1'b1;
            // emergency wins over a write in the same cycle; stays off afterwards
            if (emerg_evt) en_reg <= en_reg & ~(offsel_reg & `PMIC_OFF_MASK);
        end
    end

    // fault status: set wins over write-one-to-clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fault_sts_reg <= 8'h00;
            fault_alert_n_oe <= 1'b0;
            fault_alert_n_o <= 1'b0;
        end else begin
            fault_sts_reg <= (fault_sts_reg & ~((wr_stb_reg && wr_reg.addr == `PMIC_REG_FAULT) ? wr_reg.data : 8'h00))
                             | fault_s;
            fault_alert_n_oe <= |fault_sts_reg;
            fault_alert_n_o <= 1'b0;
        end
    end

    always_comb begin
        case (ptr_reg)
            `PMIC_REG_ENABLE: rd_data = {2'b00, en_reg};
            `PMIC_REG_OFFSEL: rd_data = {2'b00, offsel_reg};
            `PMIC_REG_RAIL_CODE: rd_data = {2'b00, rail_code_reg};
            `PMIC_REG_STEPUP_CODE: rd_data = {2'b00, stepup_code_reg};
            `PMIC_REG_STEPUP_MODE: rd_data = {7'h00, mode_reg};
            `PMIC_REG_LED_CURRENT: rd_data = {2'b00, led_reg};
            `PMIC_REG_PORT_CFG_LO: rd_data = port_cfg_reg[7:0];
            `PMIC_REG_PORT_CFG_HI: rd_data = port_cfg_reg[15:8];
            `PMIC_REG_PORT_OUT: rd_data = pout_reg;
            `PMIC_REG_PORT_PWM: rd_data = pwm_en_reg;
            `PMIC_REG_PWM_DUTY: rd_data = duty_reg;
            `PMIC_REG_PORT_IN: rd_data = pin_s;
            `PMIC_REG_FAULT: rd_data = fault_sts_reg;
            `PMIC_REG_STATUS: rd_data = {core_absent_reg, seq_on, addr_sel_reg, good_all, off_s, good_s};
            default: rd_data = 8'h00;
        endcase
    end

    // rail outputs; core, memory and io never follow the enable register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rail_en <= '0;
            analog_cfg <= '0;
        end else begin
            rail_en.internal_regulator <= seq_reg != pmic_pkg::SQ_OFF;
            rail_en.core_rail <= !core_absent_reg && seq_reg >= pmic_pkg::SQ_CORE;
            rail_en.memory_rail <= seq_reg >= pmic_pkg::SQ_MEM;
            rail_en.io_rail <= seq_reg >= pmic_pkg::SQ_IO;
            rail_en.five_volt_rail <= en_reg[`PMIC_EN_FIVE] && seq_reg >= pmic_pkg::SQ_FIVE;
            rail_en.adjustable_rail <= en_reg[`PMIC_EN_RAIL] && seq_on;
            rail_en.step_up_converter <= en_reg[`PMIC_EN_STEPUP] && seq_on;
            rail_en.load_switch <= en_reg[`PMIC_EN_LOADSW] && seq_on;
            rail_en.current_sense_amp <= en_reg[`PMIC_EN_SENSE] && seq_on;
            rail_en.uncommitted_comparator <= en_reg[`PMIC_EN_COMPAR] && seq_on;
            analog_cfg <= '{rail_code: rail_code_reg, stepup_code: stepup_code_reg,
                            stepup_volt_mode: mode_reg, led_current: led_reg};
        end
    end

    function automatic logic pin_pulled(input pmic_pkg::pmic_pin_mode_t m);
        pin_pulled = m == pmic_pkg::PM_IN_PULL || m == pmic_pkg::PM_OD_PULL;
    endfunction : pin_pulled

    function automatic logic pin_drains(input pmic_pkg::pmic_pin_mode_t m);
        pin_drains = m == pmic_pkg::PM_OD_PULL || m == pmic_pkg::PM_OD_FLOAT;
    endfunction : pin_drains

    // port pins: pwm shares one free-running counter, so one duty for all pins
    logic [7:0] pwm_cnt_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) pwm_cnt_reg <= 8'h00;
        else pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            pmic_pkg::pmic_pin_mode_t mode;
            logic low;
            assign mode = pmic_pkg::pmic_pin_mode_t'(port_cfg_reg[2*gi +: 2]);
            assign low = pwm_en_reg[gi] ? (pwm_cnt_reg >= duty_reg) : ~pout_reg[gi];
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    port_oe[gi] <= 1'b0;
                    port_pullup[gi] <= 1'b1;
                    port_o[gi] <= 1'b0;
                end else begin
                    port_oe[gi] <= pin_drains(mode) && low;
                    port_pullup[gi] <= pin_pulled(mode);
                    port_o[gi] <= 1'b0;
                end
            end
            a_pin_float: assert property (@(posedge clk_sys) disable iff (rst)
                !pin_pulled(mode) |=> !port_pullup[gi]) else $error("floating pin kept pull-up");
        end
    endgenerate

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_wake;
        seq_reg == pmic_pkg::SQ_OFF && pwr_s;
    endsequence
    sequence s_reg_up;
        seq_reg == pmic_pkg::SQ_REG ##1 rail_en.internal_regulator;
    endsequence

    a_emerg_clear: assert property (emerg_evt |=> (en_reg & $past(offsel_reg) & `PMIC_OFF_MASK) == 6'h00)
        else $error("emergency left selected converter on");
    a_emerg_gate: assert property ($fell(off_s) && !good_all && seq_on && !wr_stb_reg
        |=> $stable(en_reg)) else $error("emergency honoured with rails out");
    a_wake_order: assert property (s_wake |=> s_reg_up)
        else $error("regulator not first on wake");
    a_core_first: assert property ($rose(rail_en.memory_rail) |-> core_absent_reg || rail_en.core_rail)
        else $error("memory rail before core rail");
    a_standby_off: assert property (!pwr_s [*2] |=> rail_en == '0)
        else $error("rails on in standby");
    a_rail_code: assert property (wr_stb_reg && wr_reg.addr == `PMIC_REG_RAIL_CODE && seq_on
        |=> ##1 analog_cfg.rail_code == $past(wr_reg.data[5:0], 2)) else $error("rail code not taken");
    a_target_only: assert property (ic_reg == pmic_pkg::IC_IDLE && $past(ic_reg) == pmic_pkg::IC_IDLE |-> !sda_oe)
        else $error("data driven while idle");
    a_port_default: assert property (seq_reg == pmic_pkg::SQ_OFF |=> port_cfg_reg == `PMIC_RST_PORT_CFG)
        else $error("port not input after standby");
    a_addr_pick: assert property ($rose(addr_latched_reg) |-> addr_sel_reg == $past(pin_s[0]))
        else $error("address select not from pin zero");
    a_addr_hold: assert property (addr_latched_reg |=> $stable(addr_sel_reg))
        else $error("address select changed");
    a_fault_pin: assert property (|fault_sts_reg |=> fault_alert_n_oe)
        else $error("fault not signalled");
endmodule : pmic_ctrl
`default_nettype wire

// ==== tb/pmic_i2c_master.sv ====
// serial bus master model: start, stop, one byte with its acknowledge bit
// assumes the bench resolves sda_line from sda_m and the target's pull-down
`timescale 1ns/1ps
`default_nettype none
module pmic_i2c_master (
    // clock
    input wire logic clk_sys,
    // bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_m
);
    // last byte seen on the data line; sending all ones lets the target talk
    logic [7:0] rx;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic q(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : q
    // also a repeated start: lift data, then clock, then drop data
    task automatic start();
        sda_m = 1'b1;
        q(4);
        scl = 1'b1;
        q(4);
        sda_m = 1'b0;
        q(2);
        scl = 1'b0;
        q(2);
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        q(2);
        scl = 1'b1;
        q(2);
        sda_m = 1'b1;
        q(4);
    endtask : stop
    // eight system clocks a bit gives the 400 ns link period; the long low phase
    // covers the target's filter and register delay before the clock rises
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_m = (i > 0) ? b[i-1] : 1'b1;
            q(4);
            scl = 1'b1;
            q(2);
            if (i > 0) rx[i-1] = sda_line;
            ack = ~sda_line;
            scl = 1'b0;
            q(2);
        end
    endtask : send
endmodule : pmic_i2c_master
`default_nettype wire

// ==== tb/pmic_ctrl_tb_top.sv ====
// self-checking bench: power sequence, serial writes, emergency off, fault
// assumes four-cycle sequencer steps and the master model
`timescale 1ns/1ps
`default_nettype none
`include "pmic_params.svh"
module pmic_ctrl_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, scl, sda_m, sda_o, sda_oe, a1, a2, a3, a4;
    logic emergency_off_n = 1'b1, power_on_request = 1'b0, core_rail_feedback = 1'b0, port_supply_good = 1'b0;
    logic [2:0] rail_good = 3'h7;
    logic [7:0] fault_in = 8'h00, port_in = 8'h01, port_o, port_oe, port_pullup, rdv;
    logic fault_alert_n_o, fault_alert_n_oe;
    pmic_pkg::pmic_rails_t rail_en;
    pmic_pkg::pmic_analog_t analog_cfg;
    int n_mismatch = 0, num_checks = 0, k;
    int regs [16];
    wire logic sda_line = sda_m & ~sda_oe;
    always #25 clk_sys = ~clk_sys;
    pmic_ctrl #(.STEP_CYC(4), .NPIN(8)) u_pmic_ctrl (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .emergency_off_n(emergency_off_n),
        .power_on_request(power_on_request), .core_rail_feedback(core_rail_feedback), .rail_good(rail_good),
        .port_supply_good(port_supply_good), .fault_in(fault_in), .rail_en(rail_en), .analog_cfg(analog_cfg),
        .fault_alert_n_o(fault_alert_n_o), .fault_alert_n_oe(fault_alert_n_oe), .port_in(port_in),
        .port_o(port_o), .port_oe(port_oe), .port_pullup(port_pullup));
    pmic_i2c_master u_pmic_i2c_master (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] dev);
        regs[a[3:0]] = d;
        u_pmic_i2c_master.start();
        u_pmic_i2c_master.send(dev, a1);
        u_pmic_i2c_master.send(a, a2);
        u_pmic_i2c_master.send(d, a3);
        u_pmic_i2c_master.stop();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        u_pmic_i2c_master.start();
        u_pmic_i2c_master.send(`PMIC_WADDR_HI, a1);
        u_pmic_i2c_master.send(a, a2);
        u_pmic_i2c_master.start();
        u_pmic_i2c_master.send(`PMIC_WADDR_HI | 8'h01, a3);
        // all ones leaves data to the target and ends with no acknowledge
        u_pmic_i2c_master.send(8'hff, a4);
        d = u_pmic_i2c_master.rx;
        u_pmic_i2c_master.stop();
    endtask : rd
    task automatic wait_up();
        for (k = 0; k < 300 && rail_en.five_volt_rail !== 1'b1; k++) @(negedge clk_sys);
        if (k == 300) begin
            n_mismatch++;
            final_report();
        end
    endtask : wait_up
    task automatic w10();
        repeat (10) @(negedge clk_sys);
    endtask : w10
    initial begin
        void'($urandom(32'hc667));
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        chk("pullups", {port_pullup, port_oe}, 16'hff00);
        w10();
        port_supply_good = 1'b1;
        power_on_request = 1'b1;
        wait_up();
        chk("power up", rail_en, 10'h3e0);
        for (int a = 0; a < 6; a++) wr(8'(a), a == 0 ? 8'h3f : a == 1 ? `PMIC_OFF_MASK : 8'($urandom), `PMIC_WADDR_HI);
        chk("acks", {a1, a2, a3}, 3'h7);
        chk("rails on", rail_en, 10'h3ff);
        wr(`PMIC_REG_PORT_CFG_LO, 8'he4, `PMIC_WADDR_HI);
        chk("port modes", {port_pullup, port_oe, port_o}, 24'hf30600);
        for (int m = 0; m < 2; m++) begin
            chk("analog", analog_cfg, {regs[2][5:0], regs[3][5:0], regs[4][0], regs[5][5:0]});
            wr(`PMIC_REG_STEPUP_MODE, 8'(~regs[4]), `PMIC_WADDR_HI);
        end
        wr(`PMIC_REG_ENABLE, 8'h00, `PMIC_WADDR_LO);
        chk("wrong address", {a1, rail_en}, 11'h3ff);
        rail_good = 3'h6;
        emergency_off_n = 1'b0;
        w10();
        chk("off ignored", rail_en, 10'h3ff);
        emergency_off_n = 1'b1;
        rail_good = 3'h7;
        w10();
        emergency_off_n = 1'b0;
        w10();
        emergency_off_n = 1'b1;
        fault_in = 8'h04;
        w10();
        chk("off held", rail_en, 10'h3c7);
        chk("fault", {fault_alert_n_oe, fault_alert_n_o}, 2'h2);
        rd(`PMIC_REG_FAULT, rdv);
        chk("fault read", {a1, a2, a3, rdv}, {3'h7, fault_in});
        fault_in = 8'h00;
        wr(`PMIC_REG_FAULT, 8'hff, `PMIC_WADDR_HI);
        chk("fault clear", fault_alert_n_oe, 1'b0);
        power_on_request = 1'b0;
        w10();
        chk("standby", {rail_en, analog_cfg}, 29'h0);
        core_rail_feedback = 1'b1;
        power_on_request = 1'b1;
        wait_up();
        chk("no core", rail_en, 10'h2e0);
        final_report();
    end
endmodule : pmic_ctrl_tb_top
`default_nettype wire
